// *** core/drap_ctrl.sv ***
// Purpose: Controller end of the register access path, host bus to drive bus.
// Assumes: Host strobes and drive acknowledge are asynchronous to mclk.
// Notes: Block transfers use a separate path and never touch this logic.
`timescale 1ns/1ps
module drap_ctrl
  import drap_pkg::*;
#(
  parameter int DATA_W = DRAP_DATA_W
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_sync_strobe,
  input wire logic host_write,
  input wire logic [DRAP_DRV_W-1:0] host_drive,
  input wire logic [DRAP_REG_W-1:0] host_reg,
  input wire logic [DATA_W-1:0] host_wdata,
  output logic [DATA_W-1:0] host_rdata,
  output logic target_sync_reply,
  output logic [DRAP_NUM_LOCAL*DATA_W-1:0] local_regs,
  drap_link_if.ctrl link
);
  drap_state_t state;
  drap_state_t next_state;
  logic [DATA_W-1:0] loc [DRAP_NUM_LOCAL+1];
  logic [7:0] count;
  logic cur_write;
  logic cur_split;
  logic [DRAP_REG_W-1:0] cur_reg;
  logic [DRAP_DRV_W-1:0] drv_q;
  logic [DRAP_REG_W-1:0] reg_q;
  logic dir_q;
  logic req_q;
  logic [DATA_W-1:0] wd_q;
  logic oe_n_q;
  logic [DATA_W-1:0] rdata_q;
  logic reply_q;
  logic [DATA_W-1:0] ctl_sync;
  logic [DATA_W-1:0] hs_wdata;
  logic [DRAP_DRV_W-1:0] hs_drive;
  logic [DRAP_REG_W-1:0] hs_reg;
  logic hs_strobe;
  logic hs_write;
  logic ack_sync;

  // Host strobe, control and data pass two flops before use
  drap_sync #(.WIDTH(1)) u_sync_ack
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(link.transfer_acknowledge),
    .sync_out(ack_sync)
  );
  // Data rides with the strobe; the host sets it up a cycle ahead, so it is settled first
  drap_sync #(.WIDTH(2 + DRAP_DRV_W + DRAP_REG_W + DATA_W)) u_sync_host
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({host_sync_strobe, host_write, host_drive, host_reg, host_wdata}),
    .sync_out({hs_strobe, hs_write, hs_drive, hs_reg, hs_wdata})
  );
  drap_sync #(.WIDTH(DATA_W)) u_sync_data
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(link.ctl_data),
    .sync_out(ctl_sync)
  );

  // Address class decode of the host request
  wire [1:0] req_class = drap_class(hs_reg);
  wire is_local = (req_class == 2'h0);
  wire is_split = (req_class == 2'h2);
  wire start = hs_strobe && (state == DRAP_IDLE);
  wire cnt_done = (count == 8'h00);
  wire [2:0] loc_idx = cur_split ? 3'(DRAP_NUM_LOCAL) : cur_reg[2:0];

  // Handshake sequencing; local access skips the drive bus entirely
  always_comb
  begin
    next_state = state;
    unique case (state)
      DRAP_IDLE:
        if (start)
          next_state = is_local ? DRAP_DESKEW : DRAP_SETUP;
      DRAP_SETUP:
        if (cnt_done)
          next_state = DRAP_REQ;
      DRAP_REQ:
        if (ack_sync)
          next_state = cur_write ? DRAP_REPLY : DRAP_DESKEW;
      DRAP_DESKEW:
        if (cnt_done)
          next_state = DRAP_REPLY;
      DRAP_REPLY:
        if (!hs_strobe)
          next_state = DRAP_DRAIN;
      DRAP_DRAIN:
        if (!ack_sync)
          next_state = DRAP_IDLE;
      default:
        next_state = DRAP_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= DRAP_IDLE;
    else
      state <= next_state;
  end

  // Delay counter for select settling and read deskew
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      count <= 8'h00;
    else if (start)
      count <= is_local ? 8'(DRAP_DESKEW_CYC) : 8'(DRAP_SETUP_CYC);
    else if (state == DRAP_REQ && ack_sync)
      count <= 8'(DRAP_DESKEW_CYC);
    else if (!cnt_done)
      count <= count - 8'h01;
  end

  // Link outputs latched at the start of a remote or split access and held to the end of the cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drv_q <= '0;
      reg_q <= '0;
      dir_q <= 1'b0;
      wd_q <= '0;
      oe_n_q <= 1'b1;
      cur_write <= 1'b0;
      cur_split <= 1'b0;
      cur_reg <= '0;
    end
    else if (start)
    begin
      cur_write <= hs_write;
      cur_split <= is_split;
      cur_reg <= hs_reg;
      if (!is_local)
      begin
        drv_q <= hs_drive;
        reg_q <= hs_reg;
        dir_q <= hs_write;
        wd_q <= hs_wdata;
        oe_n_q <= !hs_write;
      end
    end
    else if (state == DRAP_IDLE)
    begin
      dir_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
  end

  // Request strobe rises after setup, falls on ack (write) or host release (read)
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      req_q <= 1'b0;
    else if (state == DRAP_SETUP && cnt_done)
      req_q <= 1'b1;
    else if (state == DRAP_REQ && ack_sync && cur_write)
      req_q <= 1'b0;
    else if (state == DRAP_REPLY && !hs_strobe)
      req_q <= 1'b0;
  end

  // Local and split register storage, plus host read data
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i <= DRAP_NUM_LOCAL; i++)
        loc[i] <= DRAP_RESET_DATA;
      rdata_q <= '0;
    end
    else if (start && is_local)
    begin
      if (hs_write)
        loc[hs_reg[2:0]] <= hs_wdata;
      else
        rdata_q <= loc[hs_reg[2:0]];
    end
    else if (state == DRAP_REQ && ack_sync)
    begin
      if (cur_split && cur_write)
        loc[loc_idx] <= wd_q;
      if (!cur_write)
        rdata_q <= cur_split ? (ctl_sync | loc[loc_idx]) : ctl_sync;
    end
  end

  // Reply to host after deskew or write acknowledge, drop when host drops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reply_q <= 1'b0;
    else
      reply_q <= (next_state == DRAP_REPLY);
  end

  // Local registers exposed for the rest of the controller
  generate
    for (genvar g = 0; g < DRAP_NUM_LOCAL; g++)
    begin : g_loc
      assign local_regs[g*DATA_W +: DATA_W] = loc[g];
    end
  endgenerate

  assign host_rdata = rdata_q;
  assign target_sync_reply = reply_q;
  assign link.drive_select = drv_q;
  assign link.register_select = reg_q;
  assign link.write_direction = dir_q;
  assign link.request_strobe = req_q;
  assign link.ctl_out_c = wd_q;
  assign link.ctl_oe_n_c = oe_n_q;
endmodule

// *** common/drap_pkg.sv ***
// Purpose: Shared constants and types for the drive register access path.
// Assumes: 200 MHz mclk, 16-bit register data, 3-bit drive select.
// Notes: Register codes below 6 are local, 6..14 remote, 15 split.
package drap_pkg;
  localparam int DRAP_DATA_W = 16;
  localparam int DRAP_DRV_W = 3;
  localparam int DRAP_REG_W = 5;
  localparam int DRAP_NUM_LOCAL = 6;
  localparam int DRAP_NUM_REMOTE = 9;
  localparam logic [4:0] DRAP_REG_LOCAL_LAST = 5'h05;
  localparam logic [4:0] DRAP_REG_REMOTE_LAST = 5'h0e;
  localparam logic [4:0] DRAP_REG_SPLIT = 5'h0f;
  // Deskew time in ns and its cycle count at 5 ns per cycle, rounded up
  localparam int DRAP_CLK_NS = 5;
  localparam int DRAP_DESKEW_NS = 75;
  localparam int DRAP_DESKEW_CYC = (DRAP_DESKEW_NS + DRAP_CLK_NS - 1) / DRAP_CLK_NS;
  // Settle time between select setup and the request strobe
  localparam int DRAP_SETUP_NS = 20;
  localparam int DRAP_SETUP_CYC = (DRAP_SETUP_NS + DRAP_CLK_NS - 1) / DRAP_CLK_NS;
  localparam logic [15:0] DRAP_RESET_DATA = 16'h0000;

  typedef enum logic [2:0]
  {
    DRAP_IDLE = 3'b000,
    DRAP_SETUP = 3'b001,
    DRAP_REQ = 3'b010,
    DRAP_DESKEW = 3'b011,
    DRAP_REPLY = 3'b100,
    DRAP_DRAIN = 3'b101
  } drap_state_t;

  // Classify a register code: 0 local, 1 remote, 2 split
  function automatic logic [1:0] drap_class(input logic [4:0] code);
    if (code <= DRAP_REG_LOCAL_LAST)
      drap_class = 2'h0;
    else if (code <= DRAP_REG_REMOTE_LAST)
      drap_class = 2'h1;
    else
      drap_class = 2'h2;
  endfunction
endpackage

// *** common/drap_link_if.sv ***
// Purpose: Drive control bus between the controller and tape controllers.
// Assumes: Data lines are two-way; enables are active low while driving.
// Notes: The wire level is resolved here from both enables.
`timescale 1ns/1ps
interface drap_link_if;
  import drap_pkg::*;
  logic [DRAP_DRV_W-1:0] drive_select;
  logic [DRAP_REG_W-1:0] register_select;
  logic write_direction;
  logic request_strobe;
  logic transfer_acknowledge;
  logic [DRAP_DATA_W-1:0] ctl_out_c;
  logic ctl_oe_n_c;
  logic [DRAP_DATA_W-1:0] ctl_out_d;
  logic ctl_oe_n_d;
  wire [DRAP_DATA_W-1:0] ctl_data;

  // Wired bus: the controller wins if both drive, released bus reads as zero
  assign ctl_data = !ctl_oe_n_c ? ctl_out_c : (!ctl_oe_n_d ? ctl_out_d : '0);

  modport ctrl
  (
    output drive_select, register_select, write_direction, request_strobe,
    output ctl_out_c, ctl_oe_n_c,
    input transfer_acknowledge, ctl_data
  );
  modport drive
  (
    input drive_select, register_select, write_direction, request_strobe,
    input ctl_data,
    output transfer_acknowledge, ctl_out_d, ctl_oe_n_d
  );
endinterface

// *** core/drap_sync.sv ***
// Purpose: Two flip-flop synchroniser for asynchronous handshake levels.
// Assumes: Inputs are levels that stay long enough to be caught.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module drap_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // Plain two-stage catch; metastability settles in stage1
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** core/drap_drive.sv ***
// Purpose: Tape controller end: nine remote registers plus its share of one split.
// Assumes: Own drive select code is a port; requests arrive asynchronously.
// Notes: Acknowledge only when this controller is the one selected.
`timescale 1ns/1ps
module drap_drive
  import drap_pkg::*;
#(
  parameter int DATA_W = DRAP_DATA_W
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [DRAP_DRV_W-1:0] my_select,
  input wire logic [DRAP_NUM_REMOTE*DATA_W-1:0] status_in,
  output logic [DRAP_NUM_REMOTE*DATA_W-1:0] remote_regs,
  drap_link_if.drive link
);
  logic [DATA_W-1:0] rr [DRAP_NUM_REMOTE+1];
  logic [DATA_W-1:0] rd_q;
  logic oe_n_q;
  logic ack_q;
  logic req_s;
  logic dir_s;
  logic [DRAP_DRV_W-1:0] drv_s;
  logic [DRAP_REG_W-1:0] reg_s;
  logic [DATA_W-1:0] data_s;

  drap_sync #(.WIDTH(2 + DRAP_DRV_W + DRAP_REG_W + DATA_W)) u_sync
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({link.request_strobe, link.write_direction, link.drive_select,
      link.register_select, link.ctl_data}),
    .sync_out({req_s, dir_s, drv_s, reg_s, data_s})
  );

  // Index of the selected register; split register sits in the last slot
  wire hit = (drv_s == my_select) && (drap_class(reg_s) != 2'h0);
  wire [3:0] idx = (reg_s == DRAP_REG_SPLIT) ? 4'(DRAP_NUM_REMOTE)
    : 4'(reg_s - DRAP_REG_LOCAL_LAST - 5'h01);

  // Write loads and acks in the same cycle; read drives data then acks next cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i <= DRAP_NUM_REMOTE; i++)
        rr[i] <= DRAP_RESET_DATA;
      rd_q <= '0;
      oe_n_q <= 1'b1;
      ack_q <= 1'b0;
    end
    else if (req_s && hit && !ack_q)
    begin
      if (dir_s)
      begin
        rr[idx] <= data_s;
        ack_q <= 1'b1;
      end
      else if (oe_n_q)
      begin
        rd_q <= (idx < 4'(DRAP_NUM_REMOTE)) ? (rr[idx] | status_in[idx*DATA_W +: DATA_W])
          : rr[idx];
        oe_n_q <= 1'b0;
      end
      else
        ack_q <= 1'b1;
    end
    else if (!req_s)
    begin
      ack_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
  end

  generate
    for (genvar g = 0; g < DRAP_NUM_REMOTE; g++)
    begin : g_rr
      assign remote_regs[g*DATA_W +: DATA_W] = rr[g];
    end
  endgenerate

  assign link.transfer_acknowledge = ack_q;
  assign link.ctl_out_d = rd_q;
  assign link.ctl_oe_n_d = oe_n_q;
endmodule

// *** bench/drap_chk.sv ***
// Purpose: Timing checks on the drive control bus between the two ends.
// Assumes: One clock domain, mclk, with the async active-low reset.
// Notes: Watches only what the two design ends drive onto the link.
`timescale 1ns/1ps
module drap_chk
  import drap_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [DRAP_DRV_W-1:0] drive_select,
  input wire logic [DRAP_REG_W-1:0] register_select,
  input wire logic write_direction,
  input wire logic request_strobe,
  input wire logic transfer_acknowledge,
  input wire logic [DRAP_DATA_W-1:0] ctl_out_c,
  input wire logic ctl_oe_n_c,
  input wire logic [DRAP_DATA_W-1:0] ctl_out_d,
  input wire logic ctl_oe_n_d,
  input wire logic [DRAP_DATA_W-1:0] ctl_data
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Addressing must not move while a request or its answer is pending
  sel_stable_a: assert property (
    (request_strobe || transfer_acknowledge) && $past(request_strobe || transfer_acknowledge)
    |-> $stable({drive_select, register_select, write_direction}))
    else $error("Drive bus addressing moved mid-cycle");
  // Selects settle for several cycles before the strobe, giving far-end skew room
  req_setup_a: assert property ($rose(request_strobe) |->
    $past(drive_select, 3) == drive_select && $past(register_select, 3) == register_select)
    else $error("Request strobe raised before selects settled");
  wr_data_a: assert property (
    $rose(request_strobe) && write_direction |-> !ctl_oe_n_c && $stable(ctl_out_c))
    else $error("Write data not in place at request");
  rd_release_a: assert property (
    request_strobe && !write_direction |-> ctl_oe_n_c)
    else $error("Controller drives data lines on a read");
  drive_gate_a: assert property (
    !ctl_oe_n_d |-> !write_direction && ctl_oe_n_c)
    else $error("Drive end drives data lines out of turn");
  ack_cause_a: assert property (
    $rose(transfer_acknowledge) |-> request_strobe)
    else $error("Acknowledge without a request");
  rd_ack_data_a: assert property (
    $rose(transfer_acknowledge) && !write_direction |-> !ctl_oe_n_d && ctl_data == ctl_out_d)
    else $error("Read acknowledged without data on the lines");
  wr_drop_a: assert property (
    request_strobe && transfer_acknowledge && write_direction |-> ##[1:6] !request_strobe)
    else $error("Write request not dropped after acknowledge");
  ack_drop_a: assert property (
    $fell(request_strobe) |-> ##[1:8] !transfer_acknowledge)
    else $error("Acknowledge held after request dropped");
endmodule

// *** bench/drap_tb_top.sv ***
// Purpose: Host accesses through both ends joined by the link interface.
// Assumes: status_in tied low, so reads return the stored values.
// Notes: my_select follows the target so all eight codes are used.
`timescale 1ns/1ps
module drap_tb_top;
  import drap_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic host_sync_strobe = 1'b0;
  logic host_write = 1'b0;
  logic [2:0] host_drive = 3'h0;
  logic [4:0] host_reg = 5'h00;
  logic [15:0] host_wdata = 16'h0000;
  logic [15:0] host_rdata;
  logic target_sync_reply;
  logic [95:0] local_regs;
  logic [143:0] remote_regs;
  logic [2:0] my_select = 3'h0;
  logic saw_req = 1'b0;
  logic [2:0] seen_drv = 3'h0;
  logic [4:0] seen_reg = 5'h00;
  logic seen_dir = 1'b0;
  logic [15:0] rd;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int ack_wait = 0;
  logic clr_rec = 1'b0;
  logic timed_out = 1'b0;

  drap_link_if lnk();
  drap_ctrl u_drap_ctrl (.mclk(mclk), .rst_n(rst_n), .host_sync_strobe(host_sync_strobe),
    .host_write(host_write), .host_drive(host_drive), .host_reg(host_reg),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .target_sync_reply(target_sync_reply),
    .local_regs(local_regs), .link(lnk));
  drap_drive u_drap_drive (.mclk(mclk), .rst_n(rst_n), .my_select(my_select),
    .status_in(144'h0), .remote_regs(remote_regs), .link(lnk));
  drap_chk u_drap_chk (.mclk(mclk), .rst_n(rst_n), .drive_select(lnk.drive_select),
    .register_select(lnk.register_select), .write_direction(lnk.write_direction),
    .request_strobe(lnk.request_strobe), .transfer_acknowledge(lnk.transfer_acknowledge),
    .ctl_out_c(lnk.ctl_out_c), .ctl_oe_n_c(lnk.ctl_oe_n_c), .ctl_out_d(lnk.ctl_out_d),
    .ctl_oe_n_d(lnk.ctl_oe_n_d), .ctl_data(lnk.ctl_data));

  always #2.5 mclk = ~mclk;

  // Record what the bus carried; the cycle ceiling cuts a hung handshake short
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    // Only this process writes the records; the access task asks for a clear
    if (clr_rec)
    begin
      saw_req <= 1'b0;
      ack_wait <= 0;
    end
    else
    begin
      if (lnk.request_strobe)
      begin
        saw_req <= 1'b1;
        seen_drv <= lnk.drive_select;
        seen_reg <= lnk.register_select;
        seen_dir <= lnk.write_direction;
      end
      if (lnk.transfer_acknowledge && !target_sync_reply)
        ack_wait <= ack_wait + 1;
    end
    if (cycles == 20000)
    begin
      timed_out = 1'b1;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Full host handshake; the next access waits for the link to fall idle
  task automatic access(input logic wr, input logic [2:0] drv, input logic [4:0] rg,
                        input logic [15:0] wd);
    @(posedge mclk);
    host_write <= wr;
    host_drive <= drv;
    host_reg <= rg;
    host_wdata <= wd;
    clr_rec <= 1'b1;
    @(posedge mclk);
    clr_rec <= 1'b0;
    host_sync_strobe <= 1'b1;
    while (target_sync_reply !== 1'b1)
      @(posedge mclk);
    rd = host_rdata;
    host_sync_strobe <= 1'b0;
    while (target_sync_reply !== 1'b0 || lnk.transfer_acknowledge !== 1'b0)
      @(posedge mclk);
  endtask

  task automatic wrap_up();
    int total;
    // A run that hit the cycle ceiling counts one mismatch
    total = n_errors + (timed_out ? 1 : 0);
    $display("Comparisons %0d, mismatches %0d", num_checks, total);
    if (total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Local registers first, then each drive code, then the split register
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      access(1'b1, 3'h0, 5'(i), 16'h1100 + 16'(i));
      check("local write", 16'h1100 + 16'(i), local_regs[i*16 +: 16]);
      access(1'b0, 3'h0, 5'(i), 16'h0000);
      check("local read", 16'h1100 + 16'(i), rd);
      check("local bus idle", 16'h0, 16'(saw_req));
    end
    for (int d = 0; d < 9; d++)
    begin
      my_select <= 3'(d);
      access(1'b1, 3'(d), 5'(6 + d), 16'ha5a0 + 16'(d));
      check("write cycle", 16'h1, 16'(saw_req));
      check("drive select", 16'(d % 8), 16'(seen_drv));
      check("register select", 16'(6 + d), 16'(seen_reg));
      check("write direction", 16'h1, 16'(seen_dir));
      check("remote store", 16'ha5a0 + 16'(d), remote_regs[d*16 +: 16]);
      access(1'b0, 3'(d), 5'(6 + d), 16'h0000);
      check("read direction", 16'h0, 16'(seen_dir));
      check("remote read", 16'ha5a0 + 16'(d), rd);
      check("deskew", 16'h1, 16'(ack_wait >= DRAP_DESKEW_CYC));
      check("request released", 16'h0, 16'(lnk.request_strobe));
    end
    access(1'b1, 3'h0, 5'h0f, 16'h5a3c);
    access(1'b0, 3'h0, 5'h0f, 16'h0000);
    check("split read", 16'h5a3c, rd);
    wrap_up();
  end
endmodule
